// File: core/bortmr_pkg.sv
/*
 * constants for the brown-out reset and power-up delay sequencer.
 * assumes a single 25 mhz core clock standing in for the internal rc clock.
 */
package bortmr_pkg;
    // ----------------------------------------------------------------
    // configuration encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] BOR_CFG_OFF = 2'h0;
    localparam logic [1:0] BOR_CFG_SOFT = 2'h1;
    localparam logic [1:0] BOR_CFG_NOSLEEP = 2'h2;
    localparam logic [1:0] BOR_CFG_ON = 2'h3;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 25000000;
    localparam int PUDLY_W = 11;
    localparam logic [PUDLY_W-1:0] PUDLY_LAST = 11'h7ff;
    localparam int OSCDLY_W = 10;
    localparam logic [OSCDLY_W-1:0] OSCDLY_LAST = 10'h3ff;
    localparam int TPLL_MS = 2;
    localparam int TPLL_CYC = (CLK_FREQ_HZ / 1000) * TPLL_MS;
    localparam int QUAL_NS = 200;
    localparam int QUAL_CYC = (QUAL_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam int QUAL_W = 8;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_STATUS_N = 1'b0;
    localparam logic RST_SOFT_EN = 1'b1;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        BORT_ST_BROWN = 5'h01,
        BORT_ST_PUDLY = 5'h02,
        BORT_ST_OSCDLY = 5'h04,
        BORT_ST_PLL = 5'h08,
        BORT_ST_RUN = 5'h10
    } bortmr_state_t;
endpackage : bortmr_pkg

// File: core/bortmr_sync.sv
/*
 * two flip-flop synchroniser for one level.
 * assumes input is asynchronous to clk.
 */
`timescale 1ns/100ps
module bortmr_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_ff;
    logic q_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule : bortmr_sync

// File: core/bortmr_top.sv
/*
 * brown-out reset qualification and power-up delay sequencer.
 * assumes power-on reset drives RSTN and the comparator and sleep pins are
 * asynchronous; firmware handles the status flags through plain ports.
 */
// Summary of operation
// - enabled config resets on qualified low supply
// - brown-out reset held while supply low
// - power-up delay starts after supply recovers
// - dip during delay restarts the count
// - brown-out enable never enables delay
// - config 01 gives software bit control
// - soft bit ignored, reads zero otherwise
// - threshold only from configuration field
// - brown-out flag cleared on each reset
// - config 10 disables detection in sleep
// - config 11 always on, 00 off
// - delay is 11-bit counter, holds reset
// - delay only when disable_n bit low
// - crystal modes add 1024 oscillator cycles
// - pll mode adds 2 ms lock delay
`timescale 1ns/100ps
module bortmr_top
    import bortmr_pkg::*;
#(
    parameter int PLL_LOCK_CYC = TPLL_CYC
) (
    // clock and power-on reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // configuration
    input wire logic [1:0] BROWNOUT_ENABLE_CFG,
    input wire logic [1:0] BROWNOUT_THRESHOLD_CFG,
    input wire logic POWERUP_DELAY_DISABLE_N,
    input wire logic XTAL_MODE,
    input wire logic PLL_MODE,
    // supply monitor and power mode
    input wire logic SUPPLY_BELOW_THRESHOLD,
    input wire logic SLEEP_MODE,
    input wire logic OSC_CLK,
    // firmware access to status
    input wire logic SOFT_BROWNOUT_ENABLE_WR,
    input wire logic SOFT_BROWNOUT_ENABLE_WDATA,
    input wire logic BROWNOUT_STATUS_N_SET,
    // outputs
    output logic [1:0] COMPARATOR_THRESHOLD_SEL,
    output logic COMPARATOR_ENABLE,
    output logic SOFT_BROWNOUT_ENABLE,
    output logic BROWNOUT_STATUS_N,
    output logic INTERNAL_RESET_N
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic below_s;
    logic sleep_s;
    logic osc_s;
    bortmr_sync u_sync_below (.clk(CORE_CLK), .rst_n(RSTN), .d(SUPPLY_BELOW_THRESHOLD),
        .q(below_s));
    bortmr_sync u_sync_sleep (.clk(CORE_CLK), .rst_n(RSTN), .d(SLEEP_MODE), .q(sleep_s));
    bortmr_sync u_sync_osc (.clk(CORE_CLK), .rst_n(RSTN), .d(OSC_CLK), .q(osc_s));

    // ----------------------------------------------------------------
    // detector enable decode
    // ----------------------------------------------------------------
    logic soft_en_ff;
    logic nxt_soft_en;
    logic det_en;
    always_comb begin
        case (BROWNOUT_ENABLE_CFG)
            BOR_CFG_SOFT: det_en = soft_en_ff;
            BOR_CFG_NOSLEEP: det_en = !sleep_s;
            BOR_CFG_ON: det_en = 1'b1;
            default: det_en = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // brown-out qualification
    // ----------------------------------------------------------------
    logic [QUAL_W-1:0] qual_ff;
    logic [QUAL_W-1:0] nxt_qual;
    logic bor_ff;
    logic nxt_bor;
    always_comb begin
        nxt_qual = '0;
        nxt_bor = bor_ff;
        if (!det_en) begin
            nxt_bor = 1'b0;
        end else if (below_s) begin
            if (bor_ff || qual_ff >= QUAL_W'(QUAL_CYC)) begin
                nxt_bor = 1'b1;
                nxt_qual = qual_ff;
            end else begin
                nxt_qual = qual_ff + QUAL_W'(1);
            end
        end else begin
            nxt_bor = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    bortmr_state_t state_ff;
    bortmr_state_t nxt_state;
    logic [PUDLY_W-1:0] pudly_ff;
    logic [PUDLY_W-1:0] nxt_pudly;
    logic [OSCDLY_W-1:0] oscdly_ff;
    logic [OSCDLY_W-1:0] nxt_oscdly;
    logic [31:0] pll_ff;
    logic [31:0] nxt_pll;
    logic osc_d_ff;
    logic osc_rise;
    bortmr_state_t after_pudly;
    bortmr_state_t after_oscdly;
    assign osc_rise = osc_s && !osc_d_ff;
    always_comb begin
        after_oscdly = PLL_MODE ? BORT_ST_PLL : BORT_ST_RUN;
        if (XTAL_MODE || PLL_MODE) begin
            after_pudly = BORT_ST_OSCDLY;
        end else begin
            after_pudly = after_oscdly;
        end
    end
    always_comb begin
        nxt_state = state_ff;
        nxt_pudly = '0;
        nxt_oscdly = '0;
        nxt_pll = '0;
        case (state_ff)
            BORT_ST_BROWN: begin
                if (!bor_ff) begin
                    nxt_state = POWERUP_DELAY_DISABLE_N ? after_pudly : BORT_ST_PUDLY;
                end
            end
            BORT_ST_PUDLY: begin
                nxt_pudly = pudly_ff + PUDLY_W'(1);
                if (pudly_ff == PUDLY_LAST) begin
                    nxt_state = after_pudly;
                end
            end
            BORT_ST_OSCDLY: begin
                nxt_oscdly = oscdly_ff;
                if (osc_rise) begin
                    nxt_oscdly = oscdly_ff + OSCDLY_W'(1);
                    if (oscdly_ff == OSCDLY_LAST) begin
                        nxt_state = after_oscdly;
                    end
                end
            end
            BORT_ST_PLL: begin
                nxt_pll = pll_ff + 32'h1;
                if (pll_ff >= 32'(PLL_LOCK_CYC - 1)) begin
                    nxt_state = BORT_ST_RUN;
                end
            end
            BORT_ST_RUN: nxt_state = BORT_ST_RUN;
            default: nxt_state = BORT_ST_BROWN;
        endcase
        if (bor_ff) begin
            nxt_state = BORT_ST_BROWN;
            nxt_pudly = '0;
        end
    end

    // ----------------------------------------------------------------
    // firmware-visible flags
    // ----------------------------------------------------------------
    logic status_n_ff;
    logic nxt_status_n;
    always_comb begin
        nxt_soft_en = soft_en_ff;
        if (SOFT_BROWNOUT_ENABLE_WR) begin
            nxt_soft_en = SOFT_BROWNOUT_ENABLE_WDATA;
        end
        nxt_status_n = status_n_ff;
        if (BROWNOUT_STATUS_N_SET) begin
            nxt_status_n = 1'b1;
        end
        if (bor_ff) begin
            nxt_status_n = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic rst_n_ff;
    logic comp_en_ff;
    logic [1:0] thr_ff;
    logic soft_rd_ff;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= BORT_ST_BROWN;
            qual_ff <= '0;
            bor_ff <= 1'b0;
            pudly_ff <= '0;
            oscdly_ff <= '0;
            pll_ff <= '0;
            osc_d_ff <= 1'b0;
            soft_en_ff <= RST_SOFT_EN;
            status_n_ff <= RST_STATUS_N;
            rst_n_ff <= 1'b0;
            comp_en_ff <= 1'b0;
            thr_ff <= 2'h0;
            soft_rd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            qual_ff <= nxt_qual;
            bor_ff <= nxt_bor;
            pudly_ff <= nxt_pudly;
            oscdly_ff <= nxt_oscdly;
            pll_ff <= nxt_pll;
            osc_d_ff <= osc_s;
            soft_en_ff <= nxt_soft_en;
            status_n_ff <= nxt_status_n;
            rst_n_ff <= (nxt_state == BORT_ST_RUN) && !nxt_bor;
            comp_en_ff <= det_en;
            thr_ff <= BROWNOUT_THRESHOLD_CFG;
            soft_rd_ff <= (BROWNOUT_ENABLE_CFG == BOR_CFG_SOFT) && nxt_soft_en;
        end
    end
    assign INTERNAL_RESET_N = rst_n_ff;
    assign COMPARATOR_ENABLE = comp_en_ff;
    assign COMPARATOR_THRESHOLD_SEL = thr_ff;
    assign SOFT_BROWNOUT_ENABLE = soft_rd_ff;
    assign BROWNOUT_STATUS_N = status_n_ff;
endmodule : bortmr_top

// File: verif/bortmr_supply_model.sv
/* supply comparator and oscillator model.
   assumes the bench commands dips and oscillator run. */
`timescale 1ns/100ps
module bortmr_supply_model (
    // commands
    input wire logic dip,
    input wire logic osc_run,
    // to block
    output logic below,
    output logic osc
);
    assign below = dip;
    // oscillator held low while stopped
    initial begin
        osc = 1'b0;
        forever begin
            #80;
            osc = osc_run ? !osc : 1'b0;
        end
    end
endmodule : bortmr_supply_model

// File: verif/bortmr_monitor.sv
/* port assertions for the sequencer.
   assumes binding to bortmr_top. */
`timescale 1ns/100ps
module bortmr_monitor
    import bortmr_pkg::*;
(
    // clock, reset, inputs
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [1:0] BROWNOUT_ENABLE_CFG,
    input wire logic [1:0] BROWNOUT_THRESHOLD_CFG,
    input wire logic POWERUP_DELAY_DISABLE_N,
    input wire logic XTAL_MODE,
    input wire logic PLL_MODE,
    input wire logic SUPPLY_BELOW_THRESHOLD,
    input wire logic SLEEP_MODE,
    // outputs
    input wire logic [1:0] COMPARATOR_THRESHOLD_SEL,
    input wire logic COMPARATOR_ENABLE,
    input wire logic SOFT_BROWNOUT_ENABLE,
    input wire logic BROWNOUT_STATUS_N,
    input wire logic INTERNAL_RESET_N
);
    default clocking cb @(posedge CORE_CLK); endclocking
    // checks held off for two edges after reset release
    logic [1:0] live_ff;
    logic [1:0] nxt_live;
    default disable iff (!RSTN || !live_ff[1]);
    // cycles since supply last seen low by an enabled detector
    logic [11:0] good_ff;
    logic [11:0] nxt_good;
    always_comb begin
        nxt_live = {live_ff[0], 1'b1};
        nxt_good = good_ff;
        if (SUPPLY_BELOW_THRESHOLD && COMPARATOR_ENABLE) begin
            nxt_good = 12'h000;
        end else if (good_ff != 12'hfff) begin
            nxt_good = good_ff + 12'h001;
        end
    end
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            good_ff <= 12'h000;
            live_ff <= 2'h0;
        end else begin
            good_ff <= nxt_good;
            live_ff <= nxt_live;
        end
    end
    sequence s_low;
        (SUPPLY_BELOW_THRESHOLD && COMPARATOR_ENABLE) [*8];
    endsequence
    sequence s_fast;
        (!SUPPLY_BELOW_THRESHOLD && POWERUP_DELAY_DISABLE_N && !XTAL_MODE && !PLL_MODE) [*8];
    endsequence
    a_thresh_follow: assert property (
        $stable(BROWNOUT_THRESHOLD_CFG) |=> COMPARATOR_THRESHOLD_SEL == $past(BROWNOUT_THRESHOLD_CFG))
        else $error("threshold select wrong");
    a_soft_zero: assert property (
        (BROWNOUT_ENABLE_CFG != BOR_CFG_SOFT) [*2] |-> !SOFT_BROWNOUT_ENABLE)
        else $error("soft enable not zero");
    a_soft_ctl: assert property (
        (BROWNOUT_ENABLE_CFG == BOR_CFG_SOFT && $stable(SOFT_BROWNOUT_ENABLE)) [*2]
        |-> COMPARATOR_ENABLE == SOFT_BROWNOUT_ENABLE) else $error("soft control wrong");
    a_fixed_cfg: assert property (
        ((BROWNOUT_ENABLE_CFG == BOR_CFG_ON || BROWNOUT_ENABLE_CFG == BOR_CFG_OFF)
        && $stable(BROWNOUT_ENABLE_CFG)) [*2]
        |-> COMPARATOR_ENABLE == BROWNOUT_ENABLE_CFG[0]) else $error("fixed config wrong");
    a_sleep_off: assert property (
        (BROWNOUT_ENABLE_CFG == BOR_CFG_NOSLEEP && SLEEP_MODE) [*4] |-> !COMPARATOR_ENABLE)
        else $error("detector on in sleep");
    a_bor_reset: assert property (
        s_low |-> ##3 (!INTERNAL_RESET_N && !BROWNOUT_STATUS_N)) else $error("no brown-out reset");
    a_delay_hold: assert property (
        $rose(INTERNAL_RESET_N) && !POWERUP_DELAY_DISABLE_N |-> good_ff >= 12'h800)
        else $error("power-up delay short");
    a_fast_release: assert property (
        s_fast |-> INTERNAL_RESET_N) else $error("reset held without cause");
endmodule : bortmr_monitor
bind bortmr_top bortmr_monitor bortmr_monitor_inst (.CORE_CLK, .RSTN, .BROWNOUT_ENABLE_CFG,
    .BROWNOUT_THRESHOLD_CFG, .POWERUP_DELAY_DISABLE_N, .XTAL_MODE, .PLL_MODE,
    .SUPPLY_BELOW_THRESHOLD, .SLEEP_MODE, .COMPARATOR_THRESHOLD_SEL, .COMPARATOR_ENABLE,
    .SOFT_BROWNOUT_ENABLE, .BROWNOUT_STATUS_N, .INTERNAL_RESET_N);

// File: verif/bortmr_tb_top.sv
/* self-checking bench for the sequencer.
   assumes the supply model drives comparator and oscillator pins. */
`timescale 1ns/100ps
module bortmr_tb_top;
    import bortmr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] en_cfg = BOR_CFG_ON;
    logic [1:0] th_cfg = 2'h0;
    logic dly_n = 1'b0;
    logic xtal = 1'b0;
    logic pll = 1'b0;
    logic dip = 1'b0;
    logic sleep = 1'b0;
    logic wr = 1'b0;
    logic wdata = 1'b0;
    logic set_st = 1'b0;
    logic below, osc, comp_en, soft_en, st_n, rst_out_n;
    logic [1:0] th_sel;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    initial begin
        forever #20 clk = !clk;
    end
    bortmr_supply_model bortmr_supply_model_inst (.dip(dip), .osc_run(xtal | pll),
        .below(below), .osc(osc));
    bortmr_top #(.PLL_LOCK_CYC(20)) bortmr_top_inst (.CORE_CLK(clk), .RSTN(rstn),
        .BROWNOUT_ENABLE_CFG(en_cfg), .BROWNOUT_THRESHOLD_CFG(th_cfg),
        .POWERUP_DELAY_DISABLE_N(dly_n), .XTAL_MODE(xtal), .PLL_MODE(pll),
        .SUPPLY_BELOW_THRESHOLD(below), .SLEEP_MODE(sleep), .OSC_CLK(osc),
        .SOFT_BROWNOUT_ENABLE_WR(wr), .SOFT_BROWNOUT_ENABLE_WDATA(wdata),
        .BROWNOUT_STATUS_N_SET(set_st), .COMPARATOR_THRESHOLD_SEL(th_sel),
        .COMPARATOR_ENABLE(comp_en), .SOFT_BROWNOUT_ENABLE(soft_en),
        .BROWNOUT_STATUS_N(st_n), .INTERNAL_RESET_N(rst_out_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_rel();
        n = 0;
        while (rst_out_n !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        check(16'(n < 20000), 16'h1);
        @(negedge clk);
    endtask : wait_rel
    task automatic brown();
        @(posedge clk) dip <= 1'b1;
        repeat (30) @(posedge clk);
        dip <= 1'b0;
        @(negedge clk);
    endtask : brown
    task automatic set_flag();
        @(posedge clk) set_st <= 1'b1;
        @(posedge clk) set_st <= 1'b0;
        repeat (2) @(negedge clk);
        check(16'(st_n), 16'h1);
    endtask : set_flag
    task automatic write_soft(input logic v);
        @(posedge clk) wr <= 1'b1;
        wdata <= v;
        @(posedge clk) wr <= 1'b0;
        repeat (6) @(negedge clk);
    endtask : write_soft
    task automatic t_power_on();
        wait_rel();
        check(16'(n >= 2048), 16'h1);
        check(16'(st_n), 16'h0);
        set_flag();
    endtask : t_power_on
    task automatic t_restart();
        brown();
        check(16'({rst_out_n, st_n}), 16'h0);
        repeat (1000) @(posedge clk);
        brown();
        wait_rel();
        check(16'(n >= 2048), 16'h1);
        set_flag();
    endtask : t_restart
    task automatic t_timers();
        int c1;
        @(posedge clk) dly_n <= 1'b1;
        brown();
        wait_rel();
        check(16'(n < 12), 16'h1);
        @(posedge clk) xtal <= 1'b1;
        brown();
        wait_rel();
        c1 = n;
        check(16'(c1 >= 4000), 16'h1);
        @(posedge clk) pll <= 1'b1;
        brown();
        wait_rel();
        check(16'(n >= c1 + 16), 16'h1);
        @(posedge clk) pll <= 1'b0;
        xtal <= 1'b0;
    endtask : t_timers
    task automatic t_modes();
        for (int c = 0; c < 4; c++) begin
            @(posedge clk) en_cfg <= 2'(c);
            th_cfg <= 2'(c);
            write_soft(1'b1);
            check(16'(th_sel), 16'(c));
            check(16'(soft_en), 16'(c == 1));
            check(16'(comp_en), 16'(c != 0));
        end
        @(posedge clk) en_cfg <= BOR_CFG_NOSLEEP;
        sleep <= 1'b1;
        write_soft(1'b1);
        check(16'(comp_en), 16'h0);
        @(posedge clk) sleep <= 1'b0;
        repeat (5) @(negedge clk);
        check(16'(comp_en), 16'h1);
        @(posedge clk) en_cfg <= BOR_CFG_SOFT;
        sleep <= 1'b0;
        write_soft(1'b0);
        check(16'({soft_en, comp_en}), 16'h0);
        brown();
        check(16'(rst_out_n), 16'h1);
        @(posedge clk) en_cfg <= BOR_CFG_ON;
    endtask : t_modes
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_power_on();
        t_restart();
        t_timers();
        t_modes();
        wrap_up();
    end
endmodule : bortmr_tb_top
